// file: core/stop_cfg.svh
// stop-mode controller constants: register map, field positions, reset values
// assumes a 32-bit classic wishbone bus with word-aligned registers
`ifndef STOP_CFG_SVH
`define STOP_CFG_SVH
`define REG_PWR_SAVE 3'h0
`define REG_PROC_CLK 3'h1
`define REG_STAB_SEL 3'h2
`define REG_PSEL 3'h3
`define REG_STAT 3'h4
`define STOP_REQ_POS 1
`define FB_CUT_POS 0
`define CPU_SUB_POS 1
`define PROC_CLK_RST 2'h0
`define STAB_SEL_W 3
`define STAB_SEL_RST 3'h6
`define PSEL_W 9
`define PSEL_RST 9'h000
`define PSEL_WIDE_WT 0
`define PSEL_N4_SUB 1
`define PSEL_N5_SUB 2
`define PSEL_N6_WOUT 3
`define PSEL_N7_WOUT 4
`define PSEL_WT_SUB 5
`define PSEL_CSI_EXT 6
`define PSEL_CSI5_EXT 7
`define PSEL_UART_EXT 8
`define IRQ_W 8
`define WDT_W 20
`define STAB_BASE 13
`endif

// file: core/stop_pkg.sv
// types shared by the stop-mode controller
// assumes the cfg header is compiled alongside
package stop_pkg;
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_STOP = 2'b01,
      ST_STAB = 2'b10
   } pwr_state_t;
   typedef struct packed {
      logic main_osc_en;
      logic main_clk_en;
      logic cpu_clk_en;
      logic periph_clk_en;
      logic sub_osc_en;
      logic sub_clk_en;
      logic sub_fb_cut;
   } clk_ctl_t;
   typedef struct packed {
      logic wide0;
      logic narrow4;
      logic narrow5;
      logic narrow6;
      logic narrow7;
      logic watch;
      logic csi;
      logic csi_fifth;
      logic uart_tx;
      logic uart_rx;
   } run_en_t;
endpackage

// file: core/stop_ctrl.sv
// software stop power-save controller with a classic wishbone register slave
// assumes synchronous interrupt masks, asynchronous pins for nmi, irqs, hold, subclock strap
//
// Contract
// RULE1 - stop mode halts main oscillator and main clock distribution
// RULE2 - subclock oscillator and subclock supply keep running in stop mode
// RULE3 - feedback-cut bit set cuts the subclock feedback resistor
// RULE4 - execution halts; registers and ram keep their values in stop
// RULE5 - peripherals stop in stop mode unless clocked from subclock
// RULE6 - bus hold requests are not granted during stop mode
// RULE7 - software requests stop only while main clock drives the cpu
// RULE8 - writing one to the stop request bit enters stop mode
// RULE9 - nmi, unmasked interrupt or reset releases stop mode
// RULE10 - release is followed by an oscillation stabilization wait
// RULE11 - first wide timer runs only on watch interval irq with subclock
// RULE12 - fourth and fifth narrow timers run only on subclock if present
// RULE13 - sixth and seventh narrow timers run on wide timer output if running
// RULE14 - watch timer runs only on subclock when subclock exists
// RULE15 - clocks to cpu and peripherals are cut in stop mode
// RULE16 - clocked serial channels run only with external serial clock
// RULE17 - async serial channels transmit only, with external baud clock
// RULE18 - stabilization length is selected by register, watchdog counter measures it
// RULE19 - after stabilization system clock restarts and the irq handler runs
`include "stop_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module stop_ctrl #(
   parameter int STAB_BASE = `STAB_BASE
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic nmi_pin,
   input wire logic [`IRQ_W-1:0] irq_pin,
   input wire logic [`IRQ_W-1:0] irq_mask,
   input wire logic bus_hold_request,
   input wire logic subclock_present,
   output logic bus_hold_ack,
   output var stop_pkg::clk_ctl_t clk_ctl,
   output var stop_pkg::run_en_t run_en,
   output logic resume_pulse,
   output logic resume_by_nmi
);
   localparam int SYNC_W = `IRQ_W + 3;

   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;
   stop_pkg::pwr_state_t state_q;
   stop_pkg::pwr_state_t state_d;
   logic [1:0] proc_clk_q;
   logic [`STAB_SEL_W-1:0] stab_sel_q;
   logic [`PSEL_W-1:0] psel_q;
   logic [`WDT_W-1:0] wdt_q;
   logic [`WDT_W-1:0] wdt_d;
   logic ack_q;
   logic [31:0] rdata_q;
   logic nmi_seen_q;
   logic resume_q;
   logic hold_ack_q;
   stop_pkg::clk_ctl_t clk_q;
   stop_pkg::clk_ctl_t clk_d;
   stop_pkg::run_en_t run_q;
   stop_pkg::run_en_t run_d;

   function automatic logic [`WDT_W-1:0] stab_limit(input logic [`STAB_SEL_W-1:0] sel);
      logic [`WDT_W:0] one;
      one = {{`WDT_W{1'b0}}, 1'b1};
      stab_limit = `WDT_W'((one << (STAB_BASE + int'(sel))) - one);
   endfunction

   // pins cross into mclk through two flops; only the second stage is read
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= {subclock_present, bus_hold_request, nmi_pin, irq_pin};
         sync2_q <= sync1_q;
      end
   end

   wire [`IRQ_W-1:0] irq_s = sync2_q[`IRQ_W-1:0];
   wire nmi_s = sync2_q[`IRQ_W];
   wire hold_s = sync2_q[`IRQ_W+1];
   wire sub_s = sync2_q[`IRQ_W+2];
   wire irq_open = |(irq_s & ~irq_mask);
   wire wake = nmi_s | irq_open;

   // bus decode
   wire req = wb_cyc_i & wb_stb_i & ~ack_q;
   wire [2:0] widx = wb_adr_i[4:2];
   wire wr = req & wb_we_i & (state_q == stop_pkg::ST_RUN);
   wire wr_lo = wr & wb_sel_i[0];
   wire wr_hi = wr & wb_sel_i[1];
   wire wr_pwr = wr_lo & (widx == `REG_PWR_SAVE);
   wire wr_proc = wr_lo & (widx == `REG_PROC_CLK);
   wire wr_stab = wr_lo & (widx == `REG_STAB_SEL);
   wire wr_psel_lo = wr_lo & (widx == `REG_PSEL);
   wire wr_psel_hi = wr_hi & (widx == `REG_PSEL);
   wire fb_cut = proc_clk_q[`FB_CUT_POS];
   wire cpu_on_sub = proc_clk_q[`CPU_SUB_POS];
   // a stop request while the cpu runs on the subclock is dropped
   wire stop_go = wr_pwr & wb_dat_i[`STOP_REQ_POS] & ~cpu_on_sub; // see RULE8 see RULE7
   wire [`WDT_W-1:0] limit = stab_limit(stab_sel_q);
   wire stab_done = (wdt_q == limit);

   always_comb begin
      state_d = state_q;
      wdt_d = wdt_q;
      case (state_q)
         stop_pkg::ST_RUN: begin
            if (stop_go) begin
               state_d = stop_pkg::ST_STOP; // see RULE8
            end
         end
         stop_pkg::ST_STOP: begin
            if (wake) begin
               state_d = stop_pkg::ST_STAB; // see RULE9
               wdt_d = '0;
            end
         end
         stop_pkg::ST_STAB: begin
            // watchdog counter measures the oscillator settling time
            if (stab_done) begin
               state_d = stop_pkg::ST_RUN; // see RULE19
            end else begin
               wdt_d = wdt_q + `WDT_W'(1); // see RULE10 see RULE18
            end
         end
         default: begin
            state_d = stop_pkg::ST_RUN;
         end
      endcase
   end

   wire run_d_mode = (state_d == stop_pkg::ST_RUN);
   wire stop_d_mode = (state_d == stop_pkg::ST_STOP);
   wire wide0_d = run_d_mode | (psel_q[`PSEL_WIDE_WT] & sub_s); // see RULE11

   always_comb begin
      clk_d.main_osc_en = ~stop_d_mode; // see RULE1
      clk_d.main_clk_en = run_d_mode; // see RULE1
      clk_d.cpu_clk_en = run_d_mode; // see RULE15 see RULE4
      clk_d.periph_clk_en = run_d_mode; // see RULE15 see RULE5
      clk_d.sub_osc_en = 1'b1; // see RULE2
      clk_d.sub_clk_en = 1'b1; // see RULE2
      // cutting feedback while running would kill the subclock, so only in stop
      clk_d.sub_fb_cut = stop_d_mode & fb_cut; // see RULE3
      run_d.wide0 = wide0_d;
      run_d.narrow4 = run_d_mode | (psel_q[`PSEL_N4_SUB] & sub_s); // see RULE12
      run_d.narrow5 = run_d_mode | (psel_q[`PSEL_N5_SUB] & sub_s); // see RULE12
      run_d.narrow6 = run_d_mode | (psel_q[`PSEL_N6_WOUT] & wide0_d); // see RULE13
      run_d.narrow7 = run_d_mode | (psel_q[`PSEL_N7_WOUT] & wide0_d); // see RULE13
      run_d.watch = run_d_mode | (psel_q[`PSEL_WT_SUB] & sub_s); // see RULE14
      run_d.csi = run_d_mode | psel_q[`PSEL_CSI_EXT]; // see RULE16
      run_d.csi_fifth = run_d_mode | psel_q[`PSEL_CSI5_EXT]; // see RULE16
      run_d.uart_tx = run_d_mode | psel_q[`PSEL_UART_EXT]; // see RULE17
      run_d.uart_rx = run_d_mode; // see RULE17 see RULE5
   end

   wire [31:0] rd_mux =
      (widx == `REG_PWR_SAVE) ? {30'h0, (state_q != stop_pkg::ST_RUN), 1'b0} :
      (widx == `REG_PROC_CLK) ? {30'h0, proc_clk_q} :
      (widx == `REG_STAB_SEL) ? {29'h0, stab_sel_q} :
      (widx == `REG_PSEL) ? {23'h0, psel_q} :
      (widx == `REG_STAT) ? {12'h0, wdt_q[`WDT_W-1:2], state_q} : 32'h0;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= stop_pkg::ST_RUN;
         wdt_q <= '0;
      end else begin
         state_q <= state_d;
         wdt_q <= wdt_d;
      end
   end

   // control registers only change in run mode, so stop keeps them intact
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         proc_clk_q <= `PROC_CLK_RST;
         stab_sel_q <= `STAB_SEL_RST;
         psel_q <= `PSEL_RST;
      end else begin
         if (wr_proc) proc_clk_q <= wb_dat_i[1:0]; // see RULE4
         if (wr_stab) stab_sel_q <= wb_dat_i[`STAB_SEL_W-1:0];
         if (wr_psel_lo) psel_q[7:0] <= wb_dat_i[7:0];
         if (wr_psel_hi) psel_q[8] <= wb_dat_i[8];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         ack_q <= req;
         rdata_q <= req ? rd_mux : '0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         clk_q <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
         run_q <= '1;
         hold_ack_q <= 1'b0;
         resume_q <= 1'b0;
         nmi_seen_q <= 1'b0;
      end else begin
         clk_q <= clk_d;
         run_q <= run_d;
         hold_ack_q <= hold_s & run_d_mode; // see RULE6
         resume_q <= (state_q == stop_pkg::ST_STAB) & stab_done; // see RULE19
         if ((state_q == stop_pkg::ST_STOP) & wake) nmi_seen_q <= nmi_s;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;
   assign clk_ctl = clk_q;
   assign run_en = run_q;
   assign bus_hold_ack = hold_ack_q;
   assign resume_pulse = resume_q;
   assign resume_by_nmi = nmi_seen_q;

   chk_stop_entry_go: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE8
      stop_go |=> (state_q == stop_pkg::ST_STOP) && !clk_ctl.cpu_clk_en)
      else $error("stop request did not enter stop");
   chk_main_osc_off: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE1
      (state_q == stop_pkg::ST_STOP) |-> !clk_ctl.main_osc_en && !clk_ctl.main_clk_en)
      else $error("main clock alive in stop");
   chk_sub_keeps: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE2
      clk_ctl.sub_osc_en && clk_ctl.sub_clk_en)
      else $error("subclock stopped");
   chk_fb_cut_sel: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE3
      (state_q == stop_pkg::ST_STOP) && $stable(state_q) |-> clk_ctl.sub_fb_cut == fb_cut)
      else $error("feedback cut mismatch");
   chk_regs_held: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE4
      (state_q != stop_pkg::ST_RUN) |=> $stable(proc_clk_q) && $stable(psel_q)
      && $stable(stab_sel_q))
      else $error("register changed while stopped");
   chk_hold_refused: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE6
      (state_q != stop_pkg::ST_RUN) |-> !bus_hold_ack)
      else $error("hold granted in stop");
   chk_wake_stab: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE9
      (state_q == stop_pkg::ST_STOP) && wake |=> (state_q == stop_pkg::ST_STAB) && wdt_q == '0)
      else $error("wake did not start settling");
   chk_stab_hold: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE10
      (state_q == stop_pkg::ST_STAB) && !stab_done |=> (state_q == stop_pkg::ST_STAB)
      && wdt_q == $past(wdt_q) + `WDT_W'(1) && !clk_ctl.cpu_clk_en)
      else $error("settling cut short");
   chk_resume_irq: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE19
      (state_q == stop_pkg::ST_STAB) && stab_done |=> resume_pulse
      && (state_q == stop_pkg::ST_RUN) && clk_ctl.cpu_clk_en ##1 !resume_pulse)
      else $error("resume not signalled");
   chk_narrow_chain: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE13
      (state_q == stop_pkg::ST_STOP) && $past(state_q == stop_pkg::ST_STOP)
      && run_en.narrow6 |-> run_en.wide0)
      else $error("sixth timer runs without wide timer");
   chk_uart_rx_off: assert property (@(posedge mclk) disable iff (!rst_n) // see RULE17
      (state_q == stop_pkg::ST_STOP) |-> !run_en.uart_rx && !clk_ctl.periph_clk_en)
      else $error("receiver alive in stop");
endmodule
`default_nettype wire

// file: verif/wake_src.sv
// wake request sources standing in for the interrupt and nmi pins
// assumes the controller's resume pulse marks entry to the handler
`timescale 1ns/10ps
`default_nettype none
module wake_src (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic fire_irq,
   input wire logic [2:0] irq_idx,
   input wire logic fire_nmi,
   input wire logic resume_pulse,
   output logic [7:0] irq_pin,
   output logic nmi_pin
);
   // requests are levels held until serviced, so a slow wake cannot lose them
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_pin <= 8'h00;
         nmi_pin <= 1'b0;
      end else if (resume_pulse) begin
         irq_pin <= 8'h00;
         nmi_pin <= 1'b0;
      end else begin
         if (fire_irq) irq_pin[irq_idx] <= 1'b1;
         if (fire_nmi) nmi_pin <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: verif/stop_ctrl_tb.sv
// self-checking bench for the stop-mode controller
// assumes the wake_src model drives the interrupt pins
`timescale 1ns/10ps
`default_nettype none
module stop_ctrl_tb;
   logic mclk = 1'b0;
   logic rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, nmi_pin, bus_hold_request;
   logic subclock_present, bus_hold_ack, resume_pulse, resume_by_nmi, fire_irq, fire_nmi;
   logic [4:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [7:0] irq_pin, irq_mask;
   logic [2:0] irq_idx;
   logic [15:0] seed;
   stop_pkg::clk_ctl_t clk_ctl;
   stop_pkg::run_en_t run_en;
   logic [31:0] expq[$];
   int fail_count = 0;
   int samples_checked = 0;
   always #12.5 mclk = ~mclk;
   // short stabilization: limit+1 = 2^(2+0) cycles with the wait select at 0
   stop_ctrl #(.STAB_BASE(2)) i_dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .nmi_pin(nmi_pin),
      .irq_pin(irq_pin), .irq_mask(irq_mask), .bus_hold_request(bus_hold_request),
      .subclock_present(subclock_present), .bus_hold_ack(bus_hold_ack), .clk_ctl(clk_ctl),
      .run_en(run_en), .resume_pulse(resume_pulse), .resume_by_nmi(resume_by_nmi));
   wake_src i_src (.mclk(mclk), .rst_n(rst_n), .fire_irq(fire_irq), .irq_idx(irq_idx),
      .fire_nmi(fire_nmi), .resume_pulse(resume_pulse), .irq_pin(irq_pin), .nmi_pin(nmi_pin));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      if (fail_count == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // classic single cycle: hold everything until ack is seen at an edge
   task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d,
                     input logic [31:0] exp);
      int n;
      n = 0;
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      if (!we) expq.push_back(exp);
      // ack is looked at mid-cycle so the edge that follows is the one that samples it high
      do begin
         @(negedge mclk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 40);
      if (n >= 40) chk(32'h0, 32'h1);
      @(posedge mclk);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   // read results are compared in order as they appear on the bus
   always @(negedge mclk) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expq.size() > 0) chk(wb_dat_o, expq.pop_front());
   end
   task automatic stop_pass(input logic sub, input logic by_nmi);
      logic [8:0] p;
      int n;
      seed = lfsr(seed);
      p = seed[8:0];
      subclock_present <= sub;
      wb(1'b1, 5'h04, 32'h1, 32'h0);
      wb(1'b1, 5'h08, 32'h0, 32'h0);
      wb(1'b1, 5'h0c, {23'h0, p}, 32'h0);
      wb(1'b1, 5'h00, 32'h2, 32'h0);
      @(negedge mclk);
      chk(32'(clk_ctl), 32'h07);
      chk(32'(run_en), {22'h0, p[0] & sub, p[1] & sub, p[2] & sub, p[3] & p[0] & sub,
         p[4] & p[0] & sub, p[5] & sub, p[6], p[7], p[8], 1'b0});
      chk(32'(bus_hold_ack), 32'h0);
      wb(1'b1, 5'h08, 32'h7, 32'h0);
      wb(1'b0, 5'h08, 32'h0, 32'h0);
      wb(1'b0, 5'h00, 32'h0, 32'h2);
      seed = lfsr(seed);
      @(posedge mclk);
      irq_idx <= seed[2:0];
      fire_irq <= 1'b1;
      @(posedge mclk);
      fire_irq <= 1'b0;
      repeat (6) @(negedge mclk);
      chk(32'(clk_ctl.main_osc_en), 32'h0);
      @(posedge mclk);
      if (by_nmi) fire_nmi <= 1'b1;
      else irq_mask <= ~(8'h01 << irq_idx);
      @(posedge mclk);
      fire_nmi <= 1'b0;
      n = 0;
      while (clk_ctl.main_osc_en !== 1'b1 && n < 40) begin
         @(negedge mclk);
         n++;
      end
      n = 0;
      while (clk_ctl.main_clk_en !== 1'b1 && n < 40) begin
         @(negedge mclk);
         n++;
      end
      chk(n, 32'h4);
      chk(32'(resume_pulse), 32'h1);
      chk(32'(resume_by_nmi), {31'h0, by_nmi});
      chk(32'(clk_ctl), 32'h7e);
      chk(32'(run_en), 32'h3ff);
      @(negedge mclk);
      chk(32'(bus_hold_ack), 32'h1);
      @(posedge mclk);
      irq_mask <= 8'hff;
   endtask
   initial begin
      rst_n = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 5'h00;
      wb_sel_i = 4'hf;
      wb_dat_i = 32'h0;
      irq_mask = 8'hff;
      bus_hold_request = 1'b1;
      subclock_present = 1'b1;
      fire_irq = 1'b0;
      fire_nmi = 1'b0;
      irq_idx = 3'h0;
      seed = 16'h000d;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      wb(1'b0, 5'h04, 32'h0, 32'h0);
      wb(1'b0, 5'h08, 32'h0, 32'h6);
      wb(1'b0, 5'h0c, 32'h0, 32'h0);
      wb(1'b0, 5'h14, 32'h0, 32'h0);
      chk(32'(bus_hold_ack), 32'h1);
      // software on the subclock must not stop; the device ignores it
      wb(1'b1, 5'h04, 32'h2, 32'h0);
      wb(1'b1, 5'h00, 32'h2, 32'h0);
      @(negedge mclk);
      chk(32'(clk_ctl.main_osc_en), 32'h1);
      wb(1'b1, 5'h04, 32'h0, 32'h0);
      stop_pass(1'b1, 1'b0);
      stop_pass(1'b0, 1'b1);
      stop_pass(1'b1, 1'b1);
      stop_pass(1'b0, 1'b0);
      wb(1'b1, 5'h00, 32'h2, 32'h0);
      rst_n <= 1'b0;
      @(posedge mclk);
      rst_n <= 1'b1;
      @(negedge mclk);
      chk(32'(clk_ctl), 32'h7e);
      final_report();
   end
   initial begin
      #(25 * 5000);
      fail_count++;
      final_report();
   end
endmodule
`default_nettype wire
